// file: afe_defines.svh
// constants for the sample-and-format block
// Behaviour
// R01 - double_sample_en high (reset value): take reference and video samples, use difference
// R02 - video level always captured on falling edge of video_sample_strobe
// R03 - in double-sample mode reference captured on falling reference_sample_strobe edge
// R04 - single-sample mode: bias reference sampled together with video level
// R05 - ext_ref_select picks bias_ref_pin, else internal 4-bit DAC code
// R06 - each channel holds own writable 8-bit offset and 9-bit gain
// R07 - range 10: zero input gives code ffff
// R08 - range 11: zero input gives code 0000
// R09 - range 00 or 01: zero input gives mid code 7fff
// R10 - converter yields 16-bit unsigned code feeding all formatting
// R11 - output_invert high gives 65535 minus code
// R12 - multiplexed 16-bit: upper byte first, then lower byte on pins 11..4
// R13 - multiplexed 12/10-bit: second byte keeps bits 7..4 or 7..6, zeros below
// R14 - parallel: 12, 10 or 8 top bits on upper pins
// R15 - controller should line-clamp and enable input buffer for AC-coupled single-sample
// R16 - output pins released when output_hiz_n low or output_disable_bit set
// R17 - words leave in conversion order, synchronous to the clock
`ifndef AFE_DEFINES_SVH
`define AFE_DEFINES_SVH
`define AFE_CODE_TOP      16'hffff
`define AFE_CODE_MID      16'h7fff
`define AFE_CODE_BOT      16'h0000
`define AFE_RANGE_NEG     2'h2
`define AFE_RANGE_POS     2'h3
`define AFE_RES_16        2'h3
`define AFE_RES_12        2'h2
`define AFE_RES_10        2'h1
`define AFE_RES_8         2'h0
`define AFE_NUM_CH        3
`define AFE_OFFSET_RESET  8'h80
`define AFE_GAIN_RESET    9'h000
`define AFE_OFFSET_MID    16'h0080
`endif

// file: afe_pkg.sv
// types for the sample-and-format block
`default_nettype none
package afe_pkg;
    typedef struct packed {
        logic [15:0] code;
        logic [1:0]  chan;
    } afe_word_t;

    typedef struct packed {
        logic [11:0] data;
        logic [11:0] oe;
    } afe_pins_t;

    typedef enum logic [1:0] {
        AFE_ST_IDLE,
        AFE_ST_FIRST,
        AFE_ST_SECOND
    } afe_fmt_state_t;
endpackage
`default_nettype wire

// file: afe_sample_format.sv
// sampling, digital code path and output packing of the front end
`timescale 1ns/1ps
`default_nettype none
`include "afe_defines.svh"
module afe_sample_format
    import afe_pkg::*;
#(
    parameter int NUM_CH = `AFE_NUM_CH
)
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    // strobes and analogue levels as digitised samples
    input  wire logic        video_sample_strobe_i,
    input  wire logic        reference_sample_strobe_i,
    input  wire logic [15:0] video_level_i,
    input  wire logic [15:0] bias_ref_pin_i,
    // configuration
    input  wire logic        double_sample_en_i,
    input  wire logic        ext_ref_select_i,
    input  wire logic [3:0]  ref_dac_code_i,
    input  wire logic [1:0]  black_level_range_sel_i,
    input  wire logic        output_invert_i,
    input  wire logic        output_pack_sel_i,
    input  wire logic [1:0]  adc_bit_width_sel_i,
    input  wire logic        input_buffer_en_i,
    input  wire logic        output_hiz_n_i,
    input  wire logic        output_disable_bit_i,
    // per-channel code writes
    input  wire logic        cal_wr_i,
    input  wire logic [1:0]  cal_chan_i,
    input  wire logic        cal_sel_gain_i,
    input  wire logic [8:0]  cal_data_i,
    // receiver handshake
    input  wire logic        out_ready_i,
    output logic             out_valid_o,
    output logic [1:0]       out_chan_o,
    output logic [11:0]      pixel_data_bus_o,
    output logic [11:0]      pixel_data_bus_oe_o,
    output logic             buffer_enabled_o
);

    // per-channel codes
    logic [7:0]  offset_reg [NUM_CH];
    logic [7:0]  offset_next [NUM_CH];
    logic [8:0]  gain_reg [NUM_CH];
    logic [8:0]  gain_next [NUM_CH];

    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            offset_next[i] = offset_reg[i];
            gain_next[i]   = gain_reg[i];
            if (cal_wr_i && cal_chan_i == 2'(i))
            begin
                if (cal_sel_gain_i)
                    gain_next[i] = cal_data_i; // R06
                else
                    offset_next[i] = cal_data_i[7:0]; // R06
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!rst_n_i)
            begin
                offset_reg[i] <= `AFE_OFFSET_RESET;
                gain_reg[i]   <= `AFE_GAIN_RESET;
            end
            else if (clk_en_i)
            begin
                offset_reg[i] <= offset_next[i];
                gain_reg[i]   <= gain_next[i];
            end
        end
    end

    // strobe edge detection and sampling
    logic        vs_d_reg, vs_d_next;
    logic        rs_d_reg, rs_d_next;
    logic [15:0] reset_lvl_reg, reset_lvl_next;
    logic        conv_reg, conv_next;
    logic [15:0] diff_reg, diff_next;
    logic [1:0]  chan_reg, chan_next;
    logic [15:0] ref_now;
    logic        vs_fall;
    logic        rs_fall;

    assign vs_fall = vs_d_reg && !video_sample_strobe_i;
    assign rs_fall = rs_d_reg && !reference_sample_strobe_i;

    always_comb
    begin
        vs_d_next      = video_sample_strobe_i;
        rs_d_next      = reference_sample_strobe_i;
        reset_lvl_next = reset_lvl_reg;
        diff_next      = diff_reg;
        conv_next      = 1'b0;
        chan_next      = chan_reg;
        // internal dac steps scale across the upper nibble
        ref_now = ext_ref_select_i ? bias_ref_pin_i : {ref_dac_code_i, 12'h000}; // R05
        if (double_sample_en_i && rs_fall)
            reset_lvl_next = video_level_i; // R03
        if (vs_fall) // R02
        begin
            conv_next = 1'b1;
            if (double_sample_en_i)
                diff_next = video_level_i - reset_lvl_reg; // R01
            else
                diff_next = video_level_i - ref_now; // R04
        end
        if (conv_reg)
            chan_next = (chan_reg == 2'(NUM_CH - 1)) ? 2'h0 : chan_reg + 2'h1; // R17
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            vs_d_reg      <= 1'b0;
            rs_d_reg      <= 1'b0;
            reset_lvl_reg <= 16'h0000;
            diff_reg      <= 16'h0000;
            conv_reg      <= 1'b0;
            chan_reg      <= 2'h0;
        end
        else if (clk_en_i)
        begin
            vs_d_reg      <= vs_d_next;
            rs_d_reg      <= rs_d_next;
            reset_lvl_reg <= reset_lvl_next;
            diff_reg      <= diff_next;
            conv_reg      <= conv_next;
            chan_reg      <= chan_next;
        end
    end

    // digital model of offset, gain and range placement
    function automatic logic [15:0] afe_convert(input logic [15:0] diff,
                                                input logic [7:0]  offs,
                                                input logic [8:0]  gain,
                                                input logic [1:0]  range);
        logic signed [17:0] v2;
        logic signed [28:0] v3;
        logic signed [19:0] base;
        logic signed [19:0] sum;
        v2   = 18'(signed'(diff)) + 18'(signed'({8'h00, offs})) - 18'(signed'(`AFE_OFFSET_MID));
        // unity at gain zero plus gain/64: cheap stand-in for the analogue curve
        v3   = 29'(v2) + ((29'(v2) * 29'(signed'({1'b0, gain}))) >>> 6);
        case (range)
            `AFE_RANGE_NEG: base = 20'(signed'({1'b0, `AFE_CODE_TOP})); // R07
            `AFE_RANGE_POS: base = 20'(signed'({1'b0, `AFE_CODE_BOT})); // R08
            default:        base = 20'(signed'({1'b0, `AFE_CODE_MID})); // R09
        endcase
        sum = base + 20'(v3);
        if (sum < 0)
            afe_convert = 16'h0000;
        else if (sum > 20'sh0ffff)
            afe_convert = 16'hffff;
        else
            afe_convert = sum[15:0]; // R10
    endfunction

    // two-entry buffer between converter and pins
    afe_word_t   buf_mem [2];
    logic        wr_ptr_reg, wr_ptr_next;
    logic        rd_ptr_reg, rd_ptr_next;
    logic [1:0]  cnt_reg, cnt_next;
    afe_word_t   in_word;
    logic        buf_push;
    logic        buf_pop;
    logic        buf_in_ready;

    // a full buffer drops the conversion; the controller must keep pace
    assign buf_in_ready = (cnt_reg != 2'h2);
    assign buf_push     = conv_reg && buf_in_ready;

    always_comb
    begin
        logic [15:0] d1;
        d1 = afe_convert(diff_reg, offset_reg[chan_reg], gain_reg[chan_reg],
                         black_level_range_sel_i);
        in_word.code = output_invert_i ? (`AFE_CODE_TOP - d1) : d1; // R11
        in_word.chan = chan_reg;
    end

    always_comb
    begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        cnt_next    = cnt_reg;
        if (buf_push)
            wr_ptr_next = ~wr_ptr_reg;
        if (buf_pop)
            rd_ptr_next = ~rd_ptr_reg;
        if (buf_push && !buf_pop)
            cnt_next = cnt_reg + 2'h1;
        else if (!buf_push && buf_pop)
            cnt_next = cnt_reg - 2'h1;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg    <= 2'h0;
        end
        else if (clk_en_i)
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
            if (buf_push)
                buf_mem[wr_ptr_reg] <= in_word;
        end
    end

    // output packing
    afe_fmt_state_t st_reg, st_next;
    logic [11:0] data_reg, data_next;
    logic [11:0] oe_reg, oe_next;
    logic        valid_reg, valid_next;
    logic [1:0]  ochan_reg, ochan_next;
    logic        benable_reg;
    afe_word_t   head;
    logic [11:0] en_mask;

    assign head    = buf_mem[rd_ptr_reg];
    assign en_mask = (!output_hiz_n_i || output_disable_bit_i) ? 12'h000 : 12'hfff; // R16

    always_comb
    begin
        st_next    = st_reg;
        data_next  = data_reg;
        valid_next = valid_reg;
        ochan_next = ochan_reg;
        buf_pop    = 1'b0;
        oe_next    = en_mask;
        case (st_reg)
            AFE_ST_IDLE:
            begin
                valid_next = 1'b0;
                if (cnt_reg != 2'h0)
                begin
                    valid_next = 1'b1;
                    ochan_next = head.chan;
                    if (!output_pack_sel_i)
                    begin
                        data_next = {head.code[15:8], 4'h0}; // R12
                        st_next   = AFE_ST_FIRST;
                    end
                    else
                    begin
                        case (adc_bit_width_sel_i) // R14
                            `AFE_RES_12: data_next = head.code[15:4];
                            `AFE_RES_10: data_next = {head.code[15:6], 2'h0};
                            `AFE_RES_8:  data_next = {head.code[15:8], 4'h0};
                            default:     data_next = head.code[15:4];
                        endcase
                        st_next = AFE_ST_SECOND;
                        buf_pop = 1'b1;
                    end
                end
            end
            AFE_ST_FIRST:
            begin
                if (out_ready_i)
                begin
                    case (adc_bit_width_sel_i) // R13
                        `AFE_RES_16: data_next = {head.code[7:0], 4'h0}; // R12
                        `AFE_RES_12: data_next = {head.code[7:4], 8'h00};
                        `AFE_RES_10: data_next = {head.code[7:6], 10'h000};
                        default:     data_next = 12'h000;
                    endcase
                    buf_pop = 1'b1;
                    st_next = AFE_ST_SECOND;
                end
            end
            AFE_ST_SECOND:
            begin
                if (out_ready_i)
                begin
                    valid_next = 1'b0;
                    st_next    = AFE_ST_IDLE;
                end
            end
            default:
                st_next = AFE_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            st_reg      <= AFE_ST_IDLE;
            data_reg    <= 12'h000;
            oe_reg      <= 12'h000;
            valid_reg   <= 1'b0;
            ochan_reg   <= 2'h0;
            benable_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            st_reg      <= st_next;
            data_reg    <= data_next;
            oe_reg      <= oe_next;
            valid_reg   <= valid_next;
            ochan_reg   <= ochan_next;
            benable_reg <= input_buffer_en_i;
        end
    end

    assign out_valid_o         = valid_reg;
    assign out_chan_o          = ochan_reg;
    assign pixel_data_bus_o    = data_reg;
    assign pixel_data_bus_oe_o = oe_reg;
    assign buffer_enabled_o    = benable_reg;

endmodule
`default_nettype wire

// file: afe_sample_format_sva.sv
// port-level checks for the sample-and-format block
`timescale 1ns/1ps
`default_nettype none
module afe_sample_format_sva
    import afe_pkg::*;
#(
    parameter int NUM_CH = 3
)
(
    // observed ports
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        clk_en_i,
    input wire logic        video_sample_strobe_i,
    input wire logic        output_pack_sel_i,
    input wire logic [1:0]  adc_bit_width_sel_i,
    input wire logic        output_hiz_n_i,
    input wire logic        output_disable_bit_i,
    input wire logic        out_ready_i,
    input wire logic        out_valid_o,
    input wire logic [1:0]  out_chan_o,
    input wire logic [11:0] pixel_data_bus_o,
    input wire logic [11:0] pixel_data_bus_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_fall;
        clk_en_i && $fell(video_sample_strobe_i) && !out_valid_o;
    endsequence
    sequence s_word;
        ##[1:8] out_valid_o;
    endsequence
    sequence s_mux_take;
        out_valid_o && out_ready_i && !output_pack_sel_i;
    endsequence

    sample_to_word_a: assert property (s_fall |-> s_word)
        else $error("no word after video strobe fall");
    reset_quiet_a: assert property (disable iff (1'b0)
        !rst_n_i |=> !out_valid_o && pixel_data_bus_oe_o == 12'h000)
        else $error("outputs active after reset");
    pins_off_a: assert property (
        (clk_en_i && (!output_hiz_n_i || output_disable_bit_i))[*4] |-> pixel_data_bus_oe_o == 12'h000)
        else $error("pins driven while disabled");
    word_hold_a: assert property (out_valid_o && !out_ready_i && clk_en_i |=>
        out_valid_o && $stable(pixel_data_bus_o) && $stable(out_chan_o))
        else $error("word changed while stalled");
    par_gap_a: assert property (out_valid_o && out_ready_i && output_pack_sel_i |=> !out_valid_o)
        else $error("no gap after parallel word");
    mux_gap_a: assert property (s_mux_take [*2] |=> !out_valid_o)
        else $error("no gap after second byte");
    mux_low12_a: assert property ((s_mux_take and adc_bit_width_sel_i == 2'h2) ##1 out_valid_o
        |-> pixel_data_bus_o[7:4] == 4'h0)
        else $error("12-bit second byte low nibble not zero");
    par8_low_a: assert property (out_valid_o && output_pack_sel_i && adc_bit_width_sel_i == 2'h0
        |-> pixel_data_bus_o[3:0] == 4'h0)
        else $error("8-bit parallel low pins not zero");
    par10_low_a: assert property (out_valid_o && output_pack_sel_i && adc_bit_width_sel_i == 2'h1
        |-> pixel_data_bus_o[1:0] == 2'h0)
        else $error("10-bit parallel low pins not zero");
    chan_range_a: assert property (out_valid_o |-> int'(out_chan_o) < NUM_CH)
        else $error("channel out of range");
endmodule

bind afe_sample_format afe_sample_format_sva #(.NUM_CH(NUM_CH)) u_afe_sample_format_sva (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .video_sample_strobe_i(video_sample_strobe_i), .output_pack_sel_i(output_pack_sel_i),
    .adc_bit_width_sel_i(adc_bit_width_sel_i), .output_hiz_n_i(output_hiz_n_i),
    .output_disable_bit_i(output_disable_bit_i), .out_ready_i(out_ready_i),
    .out_valid_o(out_valid_o), .out_chan_o(out_chan_o), .pixel_data_bus_o(pixel_data_bus_o),
    .pixel_data_bus_oe_o(pixel_data_bus_oe_o));
`default_nettype wire

// file: afe_rx_model.sv
// receiving controller model: paces ready and collects bus words
`timescale 1ns/1ps
`default_nettype none
module afe_rx_model
(
    // clock
    input  wire logic        clock_i,
    // pacing from bench
    input  wire logic        stall_i,
    input  wire logic        slow_i,
    // block output side
    input  wire logic        out_valid_i,
    input  wire logic [11:0] bus_i,
    output logic             out_ready_o
);
    logic [11:0] got[$];
    initial out_ready_o = 1'b0;
    // slow mode accepts every other cycle, so held words get exercised
    always @(posedge clock_i)
    begin
        if (out_valid_i && out_ready_o)
            got.push_back(bus_i);
        out_ready_o <= !stall_i && (!slow_i || !out_ready_o);
    end
endmodule
`default_nettype wire

// file: tb_afe_sample_and_output_format.sv
// self-checking bench for the sample-and-format block
`timescale 1ns/1ps
`default_nettype none
module tb_afe_sample_and_output_format;
    import afe_pkg::*;
    logic        clock = 1'b0, rst_n = 1'b0, vs = 1'b0, rs = 1'b0, wr = 1'b0, wgain = 1'b0;
    logic        double_sample_en = 1'b0, ext = 1'b1, inv = 1'b0, pack = 1'b1, fol = 1'b0, hizn = 1'b1;
    logic        dis = 1'b0, stall = 1'b0, slow = 1'b0, ready, valid, fol_q;
    logic [15:0] vid = 16'h0000, bias = 16'h4000, base;
    logic [3:0]  dac = 4'h0;
    logic [1:0]  range = 2'h0, res = 2'h2, wch = 2'h0, chan;
    logic [8:0]  wdata = 9'h000;
    logic [11:0] bus, oe;
    int          fails = 0, tests_run = 0;

    always #50 clock = !clock;

    afe_sample_format u_afe_sample_format (
        .clock_i(clock), .rst_n_i(rst_n), .clk_en_i(1'b1), .video_sample_strobe_i(vs),
        .reference_sample_strobe_i(rs), .video_level_i(vid), .bias_ref_pin_i(bias),
        .double_sample_en_i(double_sample_en), .ext_ref_select_i(ext), .ref_dac_code_i(dac),
        .black_level_range_sel_i(range), .output_invert_i(inv), .output_pack_sel_i(pack),
        .adc_bit_width_sel_i(res), .input_buffer_en_i(fol), .output_hiz_n_i(hizn),
        .output_disable_bit_i(dis), .cal_wr_i(wr), .cal_chan_i(wch), .cal_sel_gain_i(wgain),
        .cal_data_i(wdata), .out_ready_i(ready), .out_valid_o(valid), .out_chan_o(chan),
        .pixel_data_bus_o(bus), .pixel_data_bus_oe_o(oe), .buffer_enabled_o(fol_q));
    afe_rx_model u_afe_rx_model (.clock_i(clock), .stall_i(stall), .slow_i(slow),
        .out_valid_i(valid), .bus_i(bus), .out_ready_o(ready));

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic shot(input logic [15:0] level);
        vid = level;
        vs = 1'b1;
        step(1);
        vs = 1'b0;
        step(1);
    endtask
    task automatic cal(input logic [1:0] ch, input logic g, input logic [8:0] d);
        wch = ch;
        wgain = g;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(1);
    endtask
    // bytes of one word, packed as the current format asks
    task automatic take(input logic [15:0] code);
        logic [11:0] b0, b1;
        int          k;
        k = 0;
        b0 = {code[15:8], 4'h0};
        b1 = res == 2'h3 ? {code[7:0], 4'h0} : res == 2'h2 ? {code[7:4], 8'h0} : {code[7:6], 10'h0};
        if (pack)
            b0 = res == 2'h2 ? code[15:4] : res == 2'h1 ? {code[15:6], 2'h0} : b0;
        while (u_afe_rx_model.got.size() < (pack ? 1 : 2) && k < 60)
        begin
            step(1);
            k++;
        end
        if (u_afe_rx_model.got.size() < (pack ? 1 : 2))
        begin
            fails++;
            $display("MISMATCH t=%0t no word within bound", $time);
            end_of_test();
        end
        else if (pack)
            chk(u_afe_rx_model.got.pop_front(), b0);
        else
        begin
            chk(u_afe_rx_model.got.pop_front() & 12'hff0, b0);
            chk(u_afe_rx_model.got.pop_front() & 12'hff0, b1);
        end
    endtask

    initial
    begin
        step(12);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            range = i[1:0];
            inv = i[2];
            base = range == 2'h2 ? 16'hffff : range == 2'h3 ? 16'h0000 : 16'h7fff;
            shot(16'h4000);
            take(inv ? 16'hffff - base : base);
        end
        $display("test zero_level done");
        inv = 1'b0;
        ext = 1'b0;
        dac = 4'h3;
        for (int i = 0; i < 6; i++)
        begin
            pack = i > 2;
            res = 2'(pack ? i - 3 : i + 1);
            slow = i[0];
            shot(16'h8a3c);
            take(16'h5a3c);
        end
        $display("test formats done");
        slow = 1'b0;
        double_sample_en = 1'b1;
        vid = 16'h2000;
        rs = 1'b1;
        step(1);
        rs = 1'b0;
        step(2);
        shot(16'h2077);
        take(16'h0077);
        $display("test double_sample done");
        stall = 1'b1;
        shot(16'h2011);
        step(3);
        shot(16'h2022);
        step(6);
        stall = 1'b0;
        take(16'h0011);
        take(16'h0022);
        $display("test stall done");
        hizn = 1'b0;
        step(5);
        chk(oe, 12'h000);
        hizn = 1'b1;
        dis = 1'b1;
        step(5);
        chk(oe, 12'h000);
        dis = 1'b0;
        fol = 1'b1;
        step(2);
        chk({11'h000, fol_q}, 12'h001);
        chk(oe, 12'hfff);
        $display("test release done");
        double_sample_en = 1'b0;
        ext = 1'b1;
        pack = 1'b0;
        res = 2'h3;
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        cal(2'h1, 1'b0, 9'h082);
        cal(2'h2, 1'b1, 9'h040);
        shot(16'h4010);
        take(16'h0010);
        chk({10'h000, chan}, 12'h000);
        shot(16'h4010);
        take(16'h0012);
        chk({10'h000, chan}, 12'h001);
        shot(16'h4010);
        take(16'h0020);
        chk({10'h000, chan}, 12'h002);
        $display("test channel_codes done");
        end_of_test();
    end
endmodule
`default_nettype wire
